/* File: src/tkm_top.sv */
// Touch key measurement counters with Avalon-MM register slave
//
// Design decisions made here: the register addresses and the Avalon-MM register port.
`default_nettype none
module tkm_top
    import tkm_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic [ADDR_W-1:0] avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    output var  logic [31:0]       avs_readdata_o,
    output var  logic              avs_waitrequest_o,
    input  wire logic              first_key_osc_i,
    input  wire logic              second_key_osc_i,
    input  wire logic              ref_osc_i,
    output var  logic              osc_run_o,
    output var  logic [1:0]        osc_freq_o,
    output var  logic [9:0]        ref_cap_o,
    output var  logic              key_sel_o,
    output var  logic [7:0]        module_control0_o,
    output var  logic [7:0]        module_control1_o,
    output var  logic              irq_o
);
    // Register storage
    logic [7:0]       slot_preload;
    logic             slot_overflow_flag;
    logic             detect_start;
    logic             cf_overflow_flag;
    logic             function_overflow_flag;
    logic             ctl0_rsvd;
    logic [1:0]       function_clock_select;
    logic [7:0]       sense_control1;
    logic [7:0]       ref_cap_low;
    logic [7:0]       ref_cap_high;
    logic [7:0]       module_control0;
    logic [7:0]       module_control1;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;

    // Measurement state
    tkm_meas_e        meas_state;
    tkm_meas_e        next_meas_state;
    logic             start_prev;
    logic             key_prev;
    logic             ref_prev;
    logic [UNIT_W-1:0] unit_cnt;
    logic [UNIT_W-1:0] next_unit_cnt;
    logic [7:0]       slot_cnt;
    logic [7:0]       next_slot_cnt;
    logic [15:0]      cf_cnt;
    logic [15:0]      next_cf_cnt;
    logic [15:0]      fn_cnt;
    logic [15:0]      next_fn_cnt;

    // Bus handshake state
    logic             ack_pend;
    wire              bus_req;
    wire              acc_wr;
    wire              lane0;
    wire  [7:0]       wdata;
    wire  [7:0]       rd_byte;

    // Bus decode; a write lands only on the edge waitrequest is low
    assign bus_req = avs_read_i || avs_write_i;
    assign acc_wr  = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
    assign lane0   = avs_byteenable_i[0];
    assign wdata   = avs_writedata_i[7:0];

    function automatic logic wr_hit(input logic [3:0] idx,
                                    input logic [3:0] adr,
                                    input logic       wr);
        wr_hit = wr && (adr == idx);
    endfunction

    wire wr_preload = wr_hit(IDX_SLOT_PRELOAD, avs_address_i, acc_wr);
    wire wr_ctl0    = wr_hit(IDX_SENSE_CTL0, avs_address_i, acc_wr);
    wire wr_ctl1    = wr_hit(IDX_SENSE_CTL1, avs_address_i, acc_wr);
    wire wr_refl    = wr_hit(IDX_REF_CAP_LOW, avs_address_i, acc_wr);
    wire wr_refh    = wr_hit(IDX_REF_CAP_HIGH, avs_address_i, acc_wr);
    wire wr_mc0     = wr_hit(IDX_MODULE_CTL0, avs_address_i, acc_wr);
    wire wr_mc1     = wr_hit(IDX_MODULE_CTL1, avs_address_i, acc_wr);
    wire wr_sts     = wr_hit(IDX_IRQ_STATUS, avs_address_i, acc_wr);
    wire wr_msk     = wr_hit(IDX_IRQ_MASK, avs_address_i, acc_wr);

    // Oscillator edge detection; inputs are synchronous to clk_i
    // Key select mux
    wire key_src  = module_control0[MC0_KEY_SEL] ? second_key_osc_i : first_key_osc_i;
    wire key_rise = key_src && !key_prev;
    wire ref_rise = ref_osc_i && !ref_prev;

    // Measurement sequencing terms
    wire running   = (meas_state == MEAS_RUN);
    wire start_rise = detect_start && !start_prev;
    wire ts_tick   = running && ref_rise;
    wire unit_wrap = ts_tick && (unit_cnt == UNIT_LAST);
    wire slot_ovf  = unit_wrap && (slot_cnt == SLOT_FULL);
    wire fn_tick;
    wire cf_inc    = running && key_rise;
    wire fn_inc    = running && fn_tick;
    wire cf_evt    = cf_inc && (cf_cnt == COUNT_FULL);
    wire fn_evt    = fn_inc && (fn_cnt == COUNT_FULL);

    tkm_clk_div #(
        .WIDTH (DIV_W)
    ) u_fn_div (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .run_i     (running),
        .sel_i     (function_clock_select),
        .tick_o    (fn_tick)
    );

    // State: idle while start low, run after its rise, done on overflow
    always_comb
    begin
        next_meas_state = meas_state;
        unique case (meas_state)
            MEAS_IDLE:
                if (start_rise)
                    next_meas_state = MEAS_RUN;
            MEAS_RUN:
                if (!detect_start)
                    next_meas_state = MEAS_IDLE;
                else if (slot_ovf)
                    next_meas_state = MEAS_DONE;
            MEAS_DONE:
                if (!detect_start)
                    next_meas_state = MEAS_IDLE;
            default:
                next_meas_state = MEAS_IDLE;
        endcase
    end

    assign next_unit_cnt = !detect_start ? '0 :
                           ts_tick ? unit_cnt + UNIT_W'(1) : unit_cnt;
    // Slot counter survives start low; preload taken on start
    assign next_slot_cnt = start_rise ? slot_preload :
                           unit_wrap ? slot_cnt + 8'h01 : slot_cnt;
    assign next_cf_cnt = !detect_start ? 16'h0000 :
                         cf_inc ? cf_cnt + 16'h0001 : cf_cnt;
    assign next_fn_cnt = !detect_start ? 16'h0000 :
                         fn_inc ? fn_cnt + 16'h0001 : fn_cnt;

    // Counters and state registers
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            meas_state <= MEAS_IDLE;
            start_prev <= 1'b0;
            key_prev   <= 1'b0;
            ref_prev   <= 1'b0;
            unit_cnt   <= '0;
            slot_cnt   <= 8'h00;
            cf_cnt     <= 16'h0000;
            fn_cnt     <= 16'h0000;
        end
        else
        begin
            meas_state <= next_meas_state;
            start_prev <= detect_start;
            key_prev   <= key_src;
            ref_prev   <= ref_osc_i;
            unit_cnt   <= next_unit_cnt;
            slot_cnt   <= next_slot_cnt;
            cf_cnt     <= next_cf_cnt;
            fn_cnt     <= next_fn_cnt;
        end
    end

    // Flag next values: hardware set wins over a same-cycle clear
    // Slot overflow flag set
    wire next_slot_flag = slot_ovf ||
                          (wr_ctl0 ? wdata[CTL0_SLOT_OVF] : slot_overflow_flag);
    wire next_cf_flag = cf_evt ||
                        (cf_overflow_flag && !(wr_ctl0 && !wdata[CTL0_CF_OVF]));
    wire next_fn_flag = fn_evt ||
                        (function_overflow_flag && !(wr_ctl0 && !wdata[CTL0_FN_OVF]));

    // Interrupt events; software setting the slot flag raises none
    // Interrupt request set
    wire [IRQ_W-1:0] irq_evt = {fn_evt, cf_evt, slot_ovf};
    wire [IRQ_W-1:0] irq_clr = wr_sts ? wdata[IRQ_W-1:0] : '0;
    wire [IRQ_W-1:0] next_irq_status = (irq_status & ~irq_clr) | irq_evt;

    // Sense control 0 and interrupt registers
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            slot_overflow_flag     <= 1'b0;
            cf_overflow_flag       <= 1'b0;
            function_overflow_flag <= 1'b0;
            detect_start           <= 1'b0;
            ctl0_rsvd              <= 1'b0;
            function_clock_select  <= 2'b00;
            irq_status             <= '0;
            irq_mask               <= '0;
        end
        else
        begin
            slot_overflow_flag     <= next_slot_flag;
            cf_overflow_flag       <= next_cf_flag;
            function_overflow_flag <= next_fn_flag;
            irq_status             <= next_irq_status;
            if (wr_ctl0)
            begin
                detect_start          <= wdata[CTL0_START];
                ctl0_rsvd             <= wdata[CTL0_RSVD];
                function_clock_select <= wdata[CTL0_FCLK_LSB +: 2];
            end
            if (wr_msk)
                irq_mask <= wdata[IRQ_W-1:0];
        end
    end

    // Plain read-write configuration registers
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            slot_preload    <= RST_PRELOAD;
            sense_control1  <= RST_CTL1;
            ref_cap_low     <= RST_REF;
            ref_cap_high    <= RST_REF;
            module_control0 <= RST_MC0;
            module_control1 <= RST_MC1;
        end
        else
        begin
            if (wr_preload)
                slot_preload <= wdata;
            if (wr_ctl1)
                sense_control1 <= wdata & CTL1_MASK;
            if (wr_refl)
                ref_cap_low <= wdata;
            if (wr_refh)
                ref_cap_high <= wdata & REFH_MASK;
            if (wr_mc0)
                module_control0 <= wdata & MC0_MASK;
            if (wr_mc1)
                module_control1 <= wdata & MC1_MASK;
        end
    end

    // Read mux; unmapped words read as zero
    wire [7:0] ctl0_rd = {1'b0, slot_overflow_flag, detect_start,
                          cf_overflow_flag, function_overflow_flag,
                          ctl0_rsvd, function_clock_select};
    assign rd_byte =
        (avs_address_i == IDX_SLOT_PRELOAD)  ? slot_preload :
        (avs_address_i == IDX_SENSE_CTL0)    ? ctl0_rd :
        (avs_address_i == IDX_SENSE_CTL1)    ? sense_control1 :
        (avs_address_i == IDX_FN_COUNT_LOW)  ? fn_cnt[7:0] :
        (avs_address_i == IDX_FN_COUNT_HIGH) ? fn_cnt[15:8] :
        (avs_address_i == IDX_CF_COUNT_LOW)  ? cf_cnt[7:0] :
        (avs_address_i == IDX_CF_COUNT_HIGH) ? cf_cnt[15:8] :
        (avs_address_i == IDX_REF_CAP_LOW)   ? ref_cap_low :
        (avs_address_i == IDX_REF_CAP_HIGH)  ? ref_cap_high :
        (avs_address_i == IDX_MODULE_CTL0)   ? module_control0 :
        (avs_address_i == IDX_MODULE_CTL1)   ? module_control1 :
        (avs_address_i == IDX_IRQ_STATUS)    ? {5'h00, irq_status} :
        (avs_address_i == IDX_IRQ_MASK)      ? {5'h00, irq_mask} :
        8'h00;

    // Waitrequest drops for one cycle, one cycle after a request appears.
    // The extra cycle lets read data be registered before the master samples it.
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0000_0000;
            ack_pend          <= 1'b0;
        end
        else
        begin
            ack_pend <= 1'b0;
            if (bus_req && avs_waitrequest_o && !ack_pend)
            begin
                avs_waitrequest_o <= 1'b0;
                ack_pend          <= 1'b1;
                avs_readdata_o    <= {24'h00_0000, lane0 ? rd_byte : 8'h00};
            end
            else
                avs_waitrequest_o <= 1'b1;
        end
    end

    // Registered outputs toward the analog front end
    // Oscillators run only inside the window
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            osc_run_o         <= 1'b0;
            osc_freq_o        <= RST_CTL1[1:0];
            ref_cap_o         <= {RST_REF[1:0], RST_REF};
            key_sel_o         <= 1'b0;
            module_control0_o <= RST_MC0;
            module_control1_o <= RST_MC1;
            irq_o             <= 1'b0;
        end
        else
        begin
            osc_run_o         <= (next_meas_state == MEAS_RUN);
            osc_freq_o        <= sense_control1[1:0];
            ref_cap_o         <= {ref_cap_high[1:0], ref_cap_low};
            key_sel_o         <= module_control0[MC0_KEY_SEL];
            module_control0_o <= module_control0;
            module_control1_o <= module_control1;
            irq_o             <= |(next_irq_status & irq_mask);
        end
    end
endmodule
`default_nettype wire

/* File: common/tkm_pkg.sv */
// Constants, register map and types for the touch key measurement block
// Function
// - Window ends when time-slot counter overflows
// - Overflow sets slot flag and interrupt request
// - Software set of slot flag skips interrupt
// - Overflow stops oscillators and all counters
// - Start low clears C/F, function, unit counters
// - Start low keeps time-slot counter value
// - Start rising edge starts counters and oscillators
// - C/F overflow sets flag until written zero
// - Function overflow sets flag until written zero
// - Clock select picks fsys divided 1/2/4/8
// - Oscillator frequency select, resets to 11
// - Function count frozen and readable after overflow
// - C/F count frozen until start cleared
// - Ten-bit reference capacitor select, read-write
// - Key select routes first or second key
`default_nettype none
package tkm_pkg;
    // Word index of each register on the bus
    localparam int unsigned ADDR_W = 4;
    localparam logic [3:0] IDX_SLOT_PRELOAD  = 4'h0;
    localparam logic [3:0] IDX_SENSE_CTL0    = 4'h1;
    localparam logic [3:0] IDX_SENSE_CTL1    = 4'h2;
    localparam logic [3:0] IDX_FN_COUNT_LOW  = 4'h3;
    localparam logic [3:0] IDX_FN_COUNT_HIGH = 4'h4;
    localparam logic [3:0] IDX_CF_COUNT_LOW  = 4'h5;
    localparam logic [3:0] IDX_CF_COUNT_HIGH = 4'h6;
    localparam logic [3:0] IDX_REF_CAP_LOW   = 4'h7;
    localparam logic [3:0] IDX_REF_CAP_HIGH  = 4'h8;
    localparam logic [3:0] IDX_MODULE_CTL0   = 4'h9;
    localparam logic [3:0] IDX_MODULE_CTL1   = 4'hA;
    localparam logic [3:0] IDX_IRQ_STATUS    = 4'hB;
    localparam logic [3:0] IDX_IRQ_MASK      = 4'hC;

    // Field positions in sense_control0 and module_control0
    localparam int unsigned CTL0_SLOT_OVF = 6;
    localparam int unsigned CTL0_START    = 5;
    localparam int unsigned CTL0_CF_OVF   = 4;
    localparam int unsigned CTL0_FN_OVF   = 3;
    localparam int unsigned CTL0_RSVD     = 2;
    localparam int unsigned CTL0_FCLK_LSB = 0;
    localparam int unsigned MC0_KEY_SEL   = 6;

    // Reset values and writable-bit masks
    localparam logic [7:0] RST_PRELOAD = 8'h00;
    localparam logic [7:0] RST_CTL1    = 8'h03;
    localparam logic [7:0] RST_MC0     = 8'h00;
    localparam logic [7:0] RST_MC1     = 8'h00;
    localparam logic [7:0] RST_REF     = 8'h00;
    localparam logic [7:0] CTL1_MASK   = 8'h03;
    localparam logic [7:0] MC0_MASK    = 8'h6F;
    localparam logic [7:0] MC1_MASK    = 8'hB3;
    localparam logic [7:0] REFH_MASK   = 8'h03;

    // Counter geometry: unit period is 32 slot clocks
    localparam int unsigned UNIT_W     = 5;
    localparam logic [4:0]  UNIT_LAST  = 5'h1F;
    localparam logic [7:0]  SLOT_FULL  = 8'hFF;
    localparam logic [15:0] COUNT_FULL = 16'hFFFF;
    localparam int unsigned DIV_W      = 3;

    // Interrupt status bit positions
    localparam int unsigned IRQ_W    = 3;
    localparam int unsigned IRQ_SLOT = 0;
    localparam int unsigned IRQ_CF   = 1;
    localparam int unsigned IRQ_FN   = 2;

    typedef enum logic [1:0] {
        MEAS_IDLE = 2'b00,
        MEAS_RUN  = 2'b01,
        MEAS_DONE = 2'b10
    } tkm_meas_e;
endpackage
`default_nettype wire

/* File: src/tkm_clk_div.sv */
// Divider giving one-cycle enables at fsys, fsys/2, fsys/4 or fsys/8
`default_nettype none
module tkm_clk_div
    import tkm_pkg::*;
#(
    parameter int unsigned WIDTH = DIV_W
)(
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       run_i,
    input  wire logic [1:0] sel_i,
    output wire logic       tick_o
);
    logic [WIDTH-1:0] cnt;
    logic [WIDTH-1:0] next_cnt;
    wire  [WIDTH-1:0] sel_mask;

    // Mask of low bits that must all be one for a tick
    assign sel_mask = WIDTH'((1 << sel_i) - 1);
    assign tick_o   = run_i && ((cnt & sel_mask) == sel_mask);
    assign next_cnt = run_i ? cnt + WIDTH'(1) : '0;

    // Restarts from zero so each window sees the same phase
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            cnt <= '0;
        else
            cnt <= next_cnt;
    end
endmodule
`default_nettype wire

/* File: sim/tkm_assertions.sv */
// Port-level checker for the touch key measurement block
`default_nettype none
module tkm_assertions
    import tkm_pkg::*;
(
    input wire logic              clk_i,
    input wire logic              sys_rst_i,
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic              avs_read_i,
    input wire logic              avs_write_i,
    input wire logic [31:0]       avs_writedata_i,
    input wire logic [3:0]        avs_byteenable_i,
    input wire logic [31:0]       avs_readdata_o,
    input wire logic              avs_waitrequest_o,
    input wire logic              first_key_osc_i,
    input wire logic              second_key_osc_i,
    input wire logic              ref_osc_i,
    input wire logic              osc_run_o,
    input wire logic [1:0]        osc_freq_o,
    input wire logic [9:0]        ref_cap_o,
    input wire logic              key_sel_o,
    input wire logic [7:0]        module_control0_o,
    input wire logic [7:0]        module_control1_o,
    input wire logic              irq_o
);
    logic       start_sh;
    logic [2:0] mask_sh;
    wire  logic acc_wr = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
    wire  logic acc_rd = avs_read_i && !avs_waitrequest_o;

    // Shadows of start bit and mask, taken where a write lands
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            start_sh <= 1'b0;
            mask_sh  <= 3'h0;
        end
        else if (acc_wr && avs_address_i == IDX_SENSE_CTL0)
            start_sh <= avs_writedata_i[CTL0_START];
        else if (acc_wr && avs_address_i == IDX_IRQ_MASK)
            mask_sh <= avs_writedata_i[2:0];
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    chk_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("request not answered after one wait state");
    chk_upper_zero: assert property (acc_rd |-> avs_readdata_o[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    chk_unmapped_read: assert property (acc_rd && avs_address_i > IDX_IRQ_MASK
        |-> avs_readdata_o == 32'h0000_0000) else $error("unmapped read not zero");
    chk_idle_cleared: assert property (acc_rd && !start_sh
        && avs_address_i >= IDX_FN_COUNT_LOW && avs_address_i <= IDX_CF_COUNT_HIGH
        |-> avs_readdata_o == 32'h0000_0000) else $error("count not cleared while idle");
    chk_start_runs: assert property (acc_wr && avs_address_i == IDX_SENSE_CTL0
        && avs_writedata_i[CTL0_START] && !start_sh |-> ##2 osc_run_o)
        else $error("start did not launch the oscillators");
    chk_idle_stopped: assert property ((!start_sh) [*3] |-> !osc_run_o)
        else $error("oscillators run while start is low");
    chk_freq_copy: assert property (acc_wr && avs_address_i == IDX_SENSE_CTL1
        |=> ##1 osc_freq_o == $past(avs_writedata_i[1:0], 2))
        else $error("frequency select not output");
    chk_refcap_copy: assert property (acc_wr && avs_address_i == IDX_REF_CAP_LOW
        |=> ##1 ref_cap_o[7:0] == $past(avs_writedata_i[7:0], 2))
        else $error("reference capacitor low byte not output");
    chk_keysel_copy: assert property (acc_wr && avs_address_i == IDX_MODULE_CTL0
        |=> ##1 key_sel_o == $past(avs_writedata_i[MC0_KEY_SEL], 2))
        else $error("key select not output");
    chk_end_irq: assert property ($fell(osc_run_o) && start_sh && mask_sh[IRQ_SLOT] |-> irq_o)
        else $error("window end raised no interrupt");
    chk_irq_masked: assert property (irq_o |-> $past(mask_sh) != 3'h0)
        else $error("interrupt high with all sources masked");

    cover property ($fell(osc_run_o));
    cover property ($rose(irq_o));
    cover property (acc_rd && avs_address_i > IDX_IRQ_MASK);
endmodule

bind tkm_top tkm_assertions u_tkm_assertions (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .first_key_osc_i(first_key_osc_i), .second_key_osc_i(second_key_osc_i), .ref_osc_i(ref_osc_i),
    .osc_run_o(osc_run_o), .osc_freq_o(osc_freq_o), .ref_cap_o(ref_cap_o),
    .key_sel_o(key_sel_o), .module_control0_o(module_control0_o),
    .module_control1_o(module_control1_o), .irq_o(irq_o));
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the touch key measurement block
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp); end end
module tb
    import tkm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic              clk_i = 1'b0;
    logic              sys_rst_i = 1'b1;
    logic [ADDR_W-1:0] avs_address_i = '0;
    logic              avs_read_i = 1'b0;
    logic              avs_write_i = 1'b0;
    logic [31:0]       avs_writedata_i = '0;
    logic [3:0]        avs_byteenable_i = 4'h1;
    logic [31:0]       avs_readdata_o;
    logic              avs_waitrequest_o;
    logic              first_key_osc_i = 1'b0;
    logic              second_key_osc_i = 1'b0;
    logic              ref_osc_i = 1'b0;
    logic              osc_run_o;
    logic [1:0]        osc_freq_o;
    logic [9:0]        ref_cap_o;
    logic              key_sel_o;
    logic [7:0]        module_control0_o;
    logic [7:0]        module_control1_o;
    logic              irq_o;
    int                mismatches = 0;
    int                total_checks = 0;
    int                cycles = 0;
    int                osc_half = 0;
    int                osc_ph = 0;

    tkm_top u_tkm_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .first_key_osc_i(first_key_osc_i),
        .second_key_osc_i(second_key_osc_i), .ref_osc_i(ref_osc_i), .osc_run_o(osc_run_o),
        .osc_freq_o(osc_freq_o), .ref_cap_o(ref_cap_o), .key_sel_o(key_sel_o),
        .module_control0_o(module_control0_o),
        .module_control1_o(module_control1_o), .irq_o(irq_o));

    initial
    begin
        forever #50 clk_i = ~clk_i;
    end

    // Oscillators run only inside a window; cycle ceiling cuts a hang
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (osc_half != 0)
        begin
            osc_ph <= (osc_ph + 1 >= osc_half) ? 0 : osc_ph + 1;
            if (osc_ph + 1 >= osc_half)
            begin
                ref_osc_i  <= ~ref_osc_i;
                first_key_osc_i <= ~first_key_osc_i;
                // Second key at half rate, so key select shows in the count
                second_key_osc_i <= second_key_osc_i ^ first_key_osc_i;
            end
        end
        if (cycles == 95000)
        begin
            mismatches++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Held until waitrequest is sampled low, released at that edge
    task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk_i);
        avs_address_i   <= a;
        avs_writedata_i <= {24'h00_0000, d};
        avs_write_i     <= 1'b1;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        avs_write_i <= 1'b0;
    endtask

    task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_read_i    <= 1'b1;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        d = avs_readdata_o[7:0];
        avs_read_i <= 1'b0;
    endtask

    function automatic logic near(input logic [15:0] got, input logic [15:0] exp, input int tol);
        return (got + 16'(tol) >= exp) && (got <= exp + 16'(tol));
    endfunction

    // One window: counters cleared, then start rises with oscillators running
    task automatic measure(input logic [7:0] pre, input logic [1:0] sel, input int half);
        int n;
        bus_wr(IDX_SLOT_PRELOAD, pre);
        bus_wr(IDX_SENSE_CTL0, {6'h00, sel});
        osc_half <= half;
        bus_wr(IDX_SENSE_CTL0, {6'h08, sel});
        repeat (3) @(posedge clk_i);
        `CHK(osc_run_o, 1'b1)
        n = 0;
        while (osc_run_o !== 1'b0)
        begin
            n++;
            @(posedge clk_i);
        end
        `CHK(n > (256 - pre) * 64 * half - 16 && n < (256 - pre) * 64 * half + 16, 1'b1)
        osc_half <= 0;
    endtask

    // Reset values, masks, read-only, byte enable and unmapped places
    task automatic t_regs();
        logic [7:0] v;
        bus_rd(IDX_SENSE_CTL1, v);
        `CHK(v, 8'h03)
        `CHK(osc_freq_o, 2'b11)
        bus_wr(IDX_REF_CAP_LOW, 8'hA5);
        bus_wr(IDX_REF_CAP_HIGH, 8'hFF);
        bus_rd(IDX_REF_CAP_HIGH, v);
        `CHK(v, 8'h03)
        `CHK(ref_cap_o, 10'h3A5)
        bus_wr(IDX_SENSE_CTL1, 8'hFE);
        bus_rd(IDX_SENSE_CTL1, v);
        `CHK(v, 8'h02)
        `CHK(osc_freq_o, 2'b10)
        bus_wr(IDX_FN_COUNT_LOW, 8'h55);
        bus_rd(IDX_FN_COUNT_LOW, v);
        `CHK(v, 8'h00)
        avs_byteenable_i <= 4'h0;
        bus_wr(IDX_REF_CAP_LOW, 8'h00);
        avs_byteenable_i <= 4'h1;
        bus_rd(IDX_REF_CAP_LOW, v);
        `CHK(v, 8'hA5)
        bus_wr(4'hE, 8'hFF);
        bus_rd(4'hE, v);
        `CHK(v, 8'h00)
        bus_wr(IDX_MODULE_CTL0, 8'h40);
        bus_wr(IDX_MODULE_CTL1, 8'hFF);
        repeat (2) @(posedge clk_i);
        `CHK(key_sel_o, 1'b1)
        `CHK(module_control0_o, 8'h40)
        `CHK(module_control1_o, 8'hB3)
        bus_wr(IDX_MODULE_CTL0, 8'h00);
    endtask

    // Short windows at every clock select; length, flags and freeze
    task automatic t_window();
        logic [7:0] v;
        logic [7:0] lo;
        logic [7:0] hi;
        bus_wr(IDX_IRQ_MASK, 8'h01);
        for (int s = 0; s < 4; s++)
        begin
            bus_wr(IDX_MODULE_CTL0, (s == 3) ? 8'h40 : 8'h00);
            measure(8'hFE, s[1:0], 1);
            `CHK(irq_o, 1'b1)
            bus_rd(IDX_SENSE_CTL0, v);
            `CHK(v, 8'h60 | 8'(s))
            bus_rd(IDX_FN_COUNT_LOW, lo);
            bus_rd(IDX_FN_COUNT_HIGH, hi);
            `CHK(near({hi, lo}, 16'(128 >> s), 4), 1'b1)
            bus_rd(IDX_FN_COUNT_LOW, v);
            `CHK(v, lo)
            bus_rd(IDX_CF_COUNT_LOW, lo);
            `CHK(near({8'h00, lo}, (s == 3) ? 16'h0020 : 16'h0040, 2), 1'b1)
            bus_wr(IDX_IRQ_STATUS, 8'h01);
            bus_wr(IDX_SENSE_CTL0, 8'h00);
            `CHK(irq_o, 1'b0)
            bus_rd(IDX_FN_COUNT_LOW, v);
            `CHK(v, 8'h00)
            bus_rd(IDX_CF_COUNT_LOW, v);
            `CHK(v, 8'h00)
        end
    endtask

    // Software setting the slot flag raises no request
    task automatic t_sw_flag();
        logic [7:0] v;
        bus_wr(IDX_SENSE_CTL0, 8'h40);
        bus_rd(IDX_IRQ_STATUS, v);
        `CHK(v, 8'h00)
        `CHK(irq_o, 1'b0)
        bus_wr(IDX_SENSE_CTL0, 8'h00);
    endtask

    // Full-length window wraps the function counter; flag is sticky
    task automatic t_fn_ovf();
        logic [7:0] v;
        bus_wr(IDX_IRQ_MASK, 8'h04);
        measure(8'h00, 2'b00, 5);
        `CHK(irq_o, 1'b1)
        bus_rd(IDX_IRQ_STATUS, v);
        `CHK(v, 8'h05)
        bus_wr(IDX_SENSE_CTL0, 8'h68);
        bus_rd(IDX_SENSE_CTL0, v);
        `CHK(v, 8'h68)
        bus_wr(IDX_SENSE_CTL0, 8'h20);
        bus_rd(IDX_SENSE_CTL0, v);
        `CHK(v, 8'h20)
        bus_wr(IDX_SENSE_CTL0, 8'h00);
    endtask

    initial
    begin
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_regs();
        t_window();
        t_sw_flag();
        t_fn_ovf();
        give_verdict();
    end
endmodule
`default_nettype wire
